//--- verilog/disp_map.svh
// Register offsets, field positions, reset values and timing counts of the display scanner
`ifndef DISP_MAP_SVH
`define DISP_MAP_SVH

// ----------------------------------------
// Register and display memory addresses
// ----------------------------------------
`define DISP_CTRL_ADDR 8'h28
`define DISP_MEM_FIRST 8'h40
`define DISP_MEM_LAST 8'h55
`define DISP_MEM_BYTES 22
`define DISP_BANK_ONE 8'h01

// ----------------------------------------
// Control register fields and reset value
// ----------------------------------------
`define DISP_GRID_SEL_LSB 0
`define DISP_UNUSED_BIT 3
`define DISP_ENABLE_BIT 4
`define DISP_DIM_LSB 5
`define DISP_CTRL_RESET 8'h07
`define DISP_CTRL_WMASK 8'hf7

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define DISP_SLOT_LAST 4'hf
`define DISP_PRESCALE_LAST 2'h3
`define DISP_GRID_BASE 4'h3

`endif

//--- verilog/disp_pkg.sv
// Types shared by the display scanner and its clock divider
package disp_pkg;

  // ----------------------------------------
  // Control register layout, bit 7 first
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] dimming_width_select;
    logic display_drive_enable;
    logic unused;
    logic [2:0] grid_segment_select;
  } display_control_s;

  // ----------------------------------------
  // Scan sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    scan_idle,
    scan_run,
    scan_halted
  } scan_e;

  typedef struct packed {
    display_control_s ctrl;
    scan_e state;
    logic [3:0] grid;
    logic [3:0] phase;
    logic [10:0] grid_drive;
    logic [15:0] seg_drive;
    logic [7:0] rdata;
  } scan_state_s;

  typedef struct packed {
    logic [1:0] prescale;
    logic rtc_prev;
    logic [6:0] count;
    logic tick;
  } div_state_s;

endpackage

//--- verilog/disp_clock_divider.sv
// Driver clock: source pick, fixed /4 prescale of the system clock, then 2^n divide
`timescale 1ns/1ps
`include "disp_map.svh"

module disp_clock_divider (
  input wire logic clock_in, // System clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic src_rtc_in, // 1: real-time oscillator, 0: system clock / 4
  input wire logic rtc_osc_in, // Real-time oscillator level
  input wire logic [2:0] div_sel_in, // Divide by 2^div_sel_in
  input wire logic run_in, // Low holds the divider cleared
  output logic tick_out // One-cycle driver clock pulse
);

  disp_pkg::div_state_s st;
  disp_pkg::div_state_s next_st;
  logic src_pulse;
  logic [6:0] div_last;

  // ----------------------------------------
  // Source pulse and divide chain
  // ----------------------------------------
  // Cleared while stopped so a restarted scan gets a full first slot
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    next_st.rtc_prev = rtc_osc_in;
    next_st.prescale = run_in ? st.prescale + 2'h1 : 2'h0;
    div_last = 7'((8'h01 << div_sel_in) - 8'h01);
    if (src_rtc_in) begin
      src_pulse = rtc_osc_in && !st.rtc_prev;
    end else begin
      src_pulse = (st.prescale == `DISP_PRESCALE_LAST);
    end
    if (!run_in) begin
      next_st.count = 7'h00;
    end else if (src_pulse) begin
      if (st.count >= div_last) begin
        next_st.count = 7'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.count = st.count + 7'h01;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;

endmodule

//--- verilog/disp_grid_scan_control.sv
// Display grid and segment scanner with its control register and display memory
// What this block does
// - Select codes 000, 001, 010 give 4, 5, 6 grids with 16 segments.
// - Codes 011 to 111 give 7 to 11 grids, 15 down to 11 segments.
// - Control bit 3 has no function and always reads zero.
// - Control bit 4 set enables grid and segment driving; clear disables.
// - Dimming codes 000, 001, 010 give pulse widths 1/16, 2/16, 4/16.
// - Dimming codes 011 to 111 give widths 10/16 through 14/16.
// - Reset selects 11 grids, 11 segments, 1/16 width, display off.
// - Driver clock source is the real-time oscillator or system clock over 4.
// - An option divides that source by 2^0 up to 2^7.
// - An option decides whether driving continues while the device is halted.
// - Display bytes sit at 40H-55H, bank one, indirect access only.
// - Grid g uses bytes 40H+2g and next; low byte first, sixteen segments.
// - Memory is read continuously; a one lights a segment, zero darkens it.
`timescale 1ns/1ps
`include "disp_map.svh"

module disp_grid_scan_control (
  input wire logic clock_in, // System clock, 25 MHz
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic wr_en_in, // Data memory write strobe
  input wire logic rd_en_in, // Data memory read strobe
  input wire logic [7:0] addr_in, // Data memory address
  input wire logic [7:0] wdata_in, // Write data
  input wire logic indirect_in, // Access made through the indirect pointer one
  input wire logic [7:0] bank_pointer_in, // Current bank pointer value
  input wire logic halt_in, // Device is halted
  input wire logic keep_on_halt_in, // Option: keep driving during halt
  input wire logic src_rtc_in, // Option: 1 oscillator, 0 system clock / 4
  input wire logic rtc_osc_in, // Real-time oscillator level
  input wire logic [2:0] div_sel_in, // Option: driver clock divide 2^n
  output logic [7:0] rdata_out, // Read data, one cycle after rd_en_in
  output logic [10:0] grid_out, // Grid drives, active high
  output logic [15:0] seg_out // Segment drives, active high
);

  disp_pkg::scan_state_s st;
  disp_pkg::scan_state_s next_st;
  logic [7:0] disp_mem [0:`DISP_MEM_BYTES-1];
  logic tick;
  logic mem_hit;
  logic [4:0] mem_idx;
  logic [4:0] grid_idx;
  logic [3:0] width;
  logic [3:0] last_grid;
  logic [15:0] seg_mask;
  logic stopped;
  logic lit;

  // ----------------------------------------
  // Driver clock
  // ----------------------------------------
  disp_clock_divider u_div (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .src_rtc_in(src_rtc_in),
    .rtc_osc_in(rtc_osc_in),
    .div_sel_in(div_sel_in),
    .run_in(st.state == disp_pkg::scan_run),
    .tick_out(tick)
  );

  // ----------------------------------------
  // Address decode for display memory
  // ----------------------------------------
  // Bank zero or direct access at these addresses belongs to general RAM
  assign mem_hit = indirect_in && (bank_pointer_in == `DISP_BANK_ONE) &&
    (addr_in >= `DISP_MEM_FIRST) && (addr_in <= `DISP_MEM_LAST);
  assign mem_idx = 5'(addr_in - `DISP_MEM_FIRST);

  // Display memory writes
  always_ff @(posedge clock_in) begin
    if (wr_en_in && mem_hit) begin
      disp_mem[mem_idx] <= wdata_in;
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Grid count, segment mask and dimming width from the control fields
  always_comb begin
    last_grid = `DISP_GRID_BASE + {1'b0, st.ctrl.grid_segment_select};
    case (st.ctrl.grid_segment_select)
      3'h3: seg_mask = 16'h7fff;
      3'h4: seg_mask = 16'h3fff;
      3'h5: seg_mask = 16'h1fff;
      3'h6: seg_mask = 16'h0fff;
      3'h7: seg_mask = 16'h07ff;
      default: seg_mask = 16'hffff;
    endcase
    case (st.ctrl.dimming_width_select)
      3'h0: width = 4'h1;
      3'h1: width = 4'h2;
      3'h2: width = 4'h4;
      3'h3: width = 4'ha;
      3'h4: width = 4'hb;
      3'h5: width = 4'hc;
      3'h6: width = 4'hd;
      default: width = 4'he;
    endcase
  end

  assign stopped = halt_in && !keep_on_halt_in;
  assign grid_idx = {st.grid, 1'b0};
  assign lit = (st.state == disp_pkg::scan_run) && st.ctrl.display_drive_enable && !stopped &&
    (st.phase < width);

  // ----------------------------------------
  // Register access and scan sequencer
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // Register write; the unused bit is never stored
    if (wr_en_in && (addr_in == `DISP_CTRL_ADDR)) begin
      next_st.ctrl = disp_pkg::display_control_s'(wdata_in & `DISP_CTRL_WMASK);
    end
    // Reads answer the next cycle; other addresses read as zero here
    next_st.rdata = 8'h00;
    if (rd_en_in && (addr_in == `DISP_CTRL_ADDR)) begin
      next_st.rdata = st.ctrl & `DISP_CTRL_WMASK;
    end else if (rd_en_in && mem_hit) begin
      next_st.rdata = disp_mem[mem_idx];
    end
    // Sequencer
    case (st.state)
      disp_pkg::scan_idle: begin
        next_st.grid = 4'h0;
        next_st.phase = 4'h0;
        if (st.ctrl.display_drive_enable && !stopped) begin
          next_st.state = disp_pkg::scan_run;
        end
      end
      disp_pkg::scan_run: begin
        if (!st.ctrl.display_drive_enable) begin
          next_st.state = disp_pkg::scan_idle;
        end else if (stopped) begin
          next_st.state = disp_pkg::scan_halted;
        end else if (tick) begin
          next_st.phase = st.phase + 4'h1;
          if (st.phase == `DISP_SLOT_LAST) begin
            next_st.grid = (st.grid >= last_grid) ? 4'h0 : st.grid + 4'h1;
          end
        end
      end
      disp_pkg::scan_halted: begin
        // Position is kept so the scan resumes where it stopped
        if (!st.ctrl.display_drive_enable) begin
          next_st.state = disp_pkg::scan_idle;
        end else if (!stopped) begin
          next_st.state = disp_pkg::scan_run;
        end
      end
      default: begin
        next_st.state = disp_pkg::scan_idle;
      end
    endcase
    // Output drives: memory is sampled every cycle, so writes show at once
    next_st.grid_drive = 11'h000;
    next_st.seg_drive = 16'h0000;
    if (lit && (st.grid <= last_grid)) begin
      next_st.grid_drive = 11'(12'h001 << st.grid);
      next_st.seg_drive = {disp_mem[grid_idx + 5'h01], disp_mem[grid_idx]} & seg_mask;
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.ctrl <= disp_pkg::display_control_s'(`DISP_CTRL_RESET);
      st.state <= disp_pkg::scan_idle;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
  assign grid_out = st.grid_drive;
  assign seg_out = st.seg_drive;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence ctrl_read_s;
    rd_en_in && (addr_in == `DISP_CTRL_ADDR) && !wr_en_in;
  endsequence

  sequence disp_write_s;
    wr_en_in && mem_hit;
  endsequence

  sequence slot_end_s;
    (st.state == disp_pkg::scan_run) && st.ctrl.display_drive_enable && !stopped && tick &&
      (st.phase == `DISP_SLOT_LAST);
  endsequence

  a_reset_ctrl_value: assert property (@(posedge clock_in)
    !rst_n_in |=> (st.ctrl == `DISP_CTRL_RESET) && (grid_out == 11'h000) && (seg_out == 16'h0000))
    else $error("control reset value wrong");

  a_unused_reads_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ctrl_read_s |=> (rdata_out[3] == 1'b0) && (rdata_out[7:4] == $past(st.ctrl[7:4])))
    else $error("control read back wrong");

  a_disabled_dark: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !st.ctrl.display_drive_enable |=> (grid_out == 11'h000) && (seg_out == 16'h0000))
    else $error("outputs driven while disabled");

  a_restart_first_grid: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st.state == disp_pkg::scan_idle) ##1 (st.state == disp_pkg::scan_run) |-> (st.grid == 4'h0)
      && (st.phase == 4'h0))
    else $error("scan did not restart at grid zero");

  a_one_grid_only: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $onehot0(grid_out) && ((seg_out == 16'h0000) || (grid_out != 11'h000)))
    else $error("more than one grid driven");

  a_grid_in_range: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ##1 ((grid_out >> ($past(last_grid) + 4'h1)) == 11'h000) && ((seg_out & ~$past(seg_mask)) == 16'h0000))
    else $error("grid or segment beyond selected mode");

  a_pulse_width_gate: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st.phase >= width) |=> (grid_out == 11'h000))
    else $error("grid driven outside dimming width");

  a_grid_advance: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    slot_end_s |=> (st.grid == (($past(st.grid) >= $past(last_grid)) ? 4'h0 : $past(st.grid) + 4'h1)))
    else $error("grid did not advance in order");

  // A disable during halt still sends the position back to grid zero
  a_halt_stops_drive: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    stopped ##1 stopped |-> (grid_out == 11'h000) && ($stable(st.grid) || ($past(st.state) == disp_pkg::scan_idle)))
    else $error("driving continued during halt");

  a_memory_shows: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    disp_write_s ##1 !wr_en_in ##1 (rd_en_in && mem_hit && !wr_en_in && (mem_idx == $past(mem_idx, 2))) |=>
      (rdata_out == $past(wdata_in, 3)))
    else $error("display memory did not keep written byte");

  // ----------------------------------------
  // Sequencer and register bus checks
  // ----------------------------------------
  // State moves are checked edge by edge, so a stuck sequencer shows at once
  sequence enable_idle_s;
    (st.state == disp_pkg::scan_idle) && st.ctrl.display_drive_enable && !stopped;
  endsequence

  sequence halt_release_s;
    (st.state == disp_pkg::scan_halted) && st.ctrl.display_drive_enable && !stopped;
  endsequence

  a_enable_starts_scan: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    enable_idle_s |=> (st.state == disp_pkg::scan_run))
    else $error("scan did not start on enable");

  a_disable_stops_scan: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st.state != disp_pkg::scan_idle) && !st.ctrl.display_drive_enable |=> (st.state == disp_pkg::scan_idle))
    else $error("scan did not stop on disable");

  a_halt_enters_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st.state == disp_pkg::scan_run) && st.ctrl.display_drive_enable && stopped |=> (st.state == disp_pkg::scan_halted))
    else $error("scan did not hold on halt");

  a_halt_resumes_scan: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    halt_release_s |=> (st.state == disp_pkg::scan_run))
    else $error("scan did not resume after halt");

  a_keep_drives_halt: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st.state == disp_pkg::scan_run) && st.ctrl.display_drive_enable && halt_in && keep_on_halt_in |=> (st.state == disp_pkg::scan_run))
    else $error("scan stopped although kept on halt");

  a_phase_holds_still: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st.state == disp_pkg::scan_run) && st.ctrl.display_drive_enable && !stopped && !tick |=> $stable(st.phase) && $stable(st.grid))
    else $error("scan moved without a driver tick");

  a_phase_steps_once: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st.state == disp_pkg::scan_run) && st.ctrl.display_drive_enable && !stopped && tick |=> (st.phase == $past(st.phase) + 4'h1))
    else $error("phase did not step on driver tick");

  a_lit_grid_drive: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    lit && (st.grid <= last_grid) |=> (grid_out == 11'(12'h001 << $past(st.grid))))
    else $error("wrong grid driven");

  a_seg_from_memory: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    lit && (st.grid <= last_grid) |=> (seg_out[7:0] == $past(disp_mem[grid_idx])) &&
      (seg_out[15:8] == ($past(disp_mem[grid_idx + 5'h01]) & $past(seg_mask[15:8]))))
    else $error("segments do not follow display memory");

  a_ctrl_write_lands: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wr_en_in && (addr_in == `DISP_CTRL_ADDR) |=> (st.ctrl == ($past(wdata_in) & `DISP_CTRL_WMASK)))
    else $error("control write not stored");

  a_unmapped_reads_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    rd_en_in && (addr_in != `DISP_CTRL_ADDR) && !mem_hit |=> (rdata_out == 8'h00))
    else $error("unmapped read returned data");

  a_idle_read_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !rd_en_in |=> (rdata_out == 8'h00))
    else $error("read data without a read");

  a_tick_quiet_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st.state != disp_pkg::scan_run) |=> !tick)
    else $error("driver tick while not scanning");

endmodule

//--- tb/vfd_panel_model.sv
// Panel model: records the segment image per grid, lit stretch length and scan order
`timescale 1ns/1ps

module vfd_panel_model (
  input wire logic clock_in, // System clock
  input wire logic clear_in, // Drops the run lengths, highest grid and order flag; segment images are kept
  input wire logic [10:0] grid_in, // Grid drives from the scanner
  input wire logic [15:0] seg_in // Segment drives from the scanner
);
  logic [15:0] seg_seen [11];
  logic [7:0] run = 8'h00;
  logic [7:0] last_run = 8'h00;
  logic [3:0] prev = 4'h0;
  logic [3:0] top = 4'h0;
  logic bad_order = 1'b0;
  int idx;

  // A panel only sees the pins; two grids at once would smear digits, so flag it
  always @(posedge clock_in) begin
    idx = -1;
    for (int g = 0; g < 11; g++) begin
      if (grid_in[g]) idx = (idx == -1) ? g : 99;
    end
    if (clear_in) begin
      last_run <= 8'h00;
      run <= 8'h00;
      top <= 4'h0;
      bad_order <= 1'b0;
    end else if (idx == 99) begin
      bad_order <= 1'b1;
    end else if (idx >= 0) begin
      seg_seen[idx] <= seg_in;
      if (4'(idx) > top) top <= 4'(idx);
      if (run == 8'h00 && idx != 0 && idx != int'(prev) + 1) bad_order <= 1'b1;
      run <= run + 8'h01;
      prev <= 4'(idx);
    end else begin
      if (run != 8'h00) last_run <= run;
      run <= 8'h00;
    end
  end
endmodule

//--- tb/testbench.sv
// Register access and scan checks for the display grid scanner
`timescale 1ns/1ps

module testbench;
  logic clock_in = 1'b0, rst_n_in = 1'b0, wr_en_in = 1'b0, rd_en_in = 1'b0, indirect_in = 1'b0;
  logic halt_in = 1'b0, keep_on_halt_in = 1'b0, src_rtc_in = 1'b0, rtc_osc_in = 1'b0, clear = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, bank_pointer_in = 8'h00, rdata_out;
  logic [2:0] div_sel_in = 3'h0;
  logic [10:0] grid_out;
  logic [15:0] seg_out;
  int mismatches = 0, n_compared = 0;
  int widths [8] = '{1, 2, 4, 10, 11, 12, 13, 14};

  disp_grid_scan_control u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .indirect_in(indirect_in),
    .bank_pointer_in(bank_pointer_in), .halt_in(halt_in), .keep_on_halt_in(keep_on_halt_in),
    .src_rtc_in(src_rtc_in), .rtc_osc_in(rtc_osc_in), .div_sel_in(div_sel_in),
    .rdata_out(rdata_out), .grid_out(grid_out), .seg_out(seg_out));
  vfd_panel_model u_panel (.clock_in(clock_in), .clear_in(clear), .grid_in(grid_out), .seg_in(seg_out));

  // ----------------------------------------
  // Clock, oscillator and watchdog
  // ----------------------------------------
  always #20 clock_in = ~clock_in;
  // Oscillator only runs while selected: one rising edge every two clocks
  always @(posedge clock_in) begin
    if (src_rtc_in) rtc_osc_in <= ~rtc_osc_in;
  end
  initial begin
    #(40 * 40000);
    mismatches++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ind, input logic [7:0] bp);
    @(posedge clock_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    indirect_in <= ind;
    bank_pointer_in <= bp;
    @(posedge clock_in);
    wr_en_in <= 1'b0;
  endtask
  // Read data stands for one cycle only, so it is sampled just after the answering edge
  task automatic rd_chk(input string what, input logic [7:0] a, input logic ind, input logic [7:0] bp,
    input logic [7:0] exp);
    @(posedge clock_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    indirect_in <= ind;
    bank_pointer_in <= bp;
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdata_out});
  endtask
  task automatic clear_panel;
    @(posedge clock_in);
    clear <= 1'b1;
    @(posedge clock_in);
    clear <= 1'b0;
  endtask
  // Disable first so every scan starts from grid zero
  task automatic scan(input logic [2:0] sel, input logic [2:0] dim, input int n);
    wr(8'h28, {dim, 2'b00, sel}, 1'b0, 8'h00);
    wr(8'h28, {dim, 2'b10, sel}, 1'b0, 8'h00);
    clear_panel();
    repeat (n) @(posedge clock_in);
  endtask
  function automatic logic [15:0] exp_seg(input int sel, input int g);
    int n;
    n = (sel < 3) ? 16 : 18 - sel;
    return {8'hf0 | 8'((2 * g + 1) & 15), 8'hf0 | 8'((2 * g) & 15)} & 16'((17'h1 << n) - 1);
  endfunction
  task automatic tally_and_finish;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    #1;
    chk("grid after reset", 16'h0000, {5'h00, grid_out});
    rd_chk("control reset", 8'h28, 1'b0, 8'h00, 8'h07);
    wr(8'h28, 8'hef, 1'b0, 8'h00);
    rd_chk("control bit three", 8'h28, 1'b0, 8'h00, 8'he7);
    for (int i = 0; i < 22; i++) begin
      wr(8'(8'h40 + i), 8'hf0 | 8'(i & 15), 1'b1, 8'h01);
    end
    // Bank zero and direct writes must leave the display bytes alone
    wr(8'h40, 8'h00, 1'b1, 8'h00);
    wr(8'h41, 8'h00, 1'b0, 8'h01);
    rd_chk("display first", 8'h40, 1'b1, 8'h01, 8'hf0);
    rd_chk("display direct", 8'h41, 1'b0, 8'h01, 8'h00);
    rd_chk("display bank zero", 8'h55, 1'b1, 8'h00, 8'h00);
    rd_chk("display last", 8'h55, 1'b1, 8'h01, 8'hf5);
    rd_chk("unmapped", 8'h56, 1'b1, 8'h01, 8'h00);
    wr(8'h55, 8'h5a, 1'b1, 8'h01);
    rd_chk("display rewrite", 8'h55, 1'b1, 8'h01, 8'h5a);
    wr(8'h55, 8'hf5, 1'b1, 8'h01);
    for (int s = 0; s < 8; s++) begin
      scan(3'(s), 3'h7, 12 * 64);
      chk("grid count", 16'(3 + s), {12'h000, u_panel.top});
      chk("grid order", 16'h0000, {15'h0000, u_panel.bad_order});
      for (int g = 0; g <= 3 + s; g++) begin
        chk("segments", exp_seg(s, g), u_panel.seg_seen[g]);
      end
    end
    for (int d = 0; d < 8; d++) begin
      scan(3'h0, 3'(d), 3 * 64);
      chk("pulse width", 16'(4 * widths[d]), {8'h00, u_panel.last_run});
    end
    div_sel_in <= 3'h2;
    scan(3'h0, 3'h2, 3 * 256);
    chk("divided width", 16'd64, {8'h00, u_panel.last_run});
    div_sel_in <= 3'h0;
    src_rtc_in <= 1'b1;
    scan(3'h0, 3'h2, 3 * 128);
    chk("oscillator width", 16'd8, {8'h00, u_panel.last_run});
    src_rtc_in <= 1'b0;
    scan(3'h0, 3'h2, 128);
    halt_in <= 1'b1;
    clear_panel();
    repeat (200) @(posedge clock_in);
    chk("halt dark", 16'h0000, {8'h00, u_panel.last_run});
    chk("halt grid", 16'h0000, {5'h00, grid_out});
    halt_in <= 1'b0;
    keep_on_halt_in <= 1'b1;
    repeat (100) @(posedge clock_in);
    halt_in <= 1'b1;
    clear_panel();
    repeat (200) @(posedge clock_in);
    chk("halt kept", 16'd16, {8'h00, u_panel.last_run});
    halt_in <= 1'b0;
    wr(8'h28, 8'h42, 1'b0, 8'h00);
    repeat (2) @(posedge clock_in);
    #1;
    chk("disabled", 16'h0000, seg_out | {5'h00, grid_out});
    wr(8'h28, 8'h52, 1'b0, 8'h00);
    for (int k = 0; k < 200 && grid_out === 11'h000; k++) begin
      @(posedge clock_in);
      #1;
    end
    chk("restart grid", 16'h0001, {5'h00, grid_out});
    tally_and_finish();
  end
endmodule
